// ### hw/sebf_fifo.sv
// Purpose: Small flop FIFO with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   Full and empty are exact; no bypass, so latency is one cycle.
`timescale 1ns/100ps
module sebf_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } sebf_fifo_t;

    sebf_fifo_t q;
    sebf_fifo_t d;
    logic       push;
    logic       pop;

    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap by index; depth is a power of two
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (pop)
            d.rp = q.rp + 1'b1;
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end
endmodule

// ### hw/sebf_master.sv
// Purpose: Two-wire bus master end; one command moves one byte.
// Assumes: Slave never stretches the clock.
// Notes:   The clock is made here from a divider; sda is synchronised.
`timescale 1ns/100ps
module sebf_master
    import sebf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    sebf_link_if.mst        link,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_wdata,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_ack
);
    typedef enum logic [2:0] {
        SEBM_IDLE, SEBM_START, SEBM_BIT, SEBM_STOP
    } sebf_mst_st_t;

    typedef struct packed {
        logic [1:0]   s1;      // {sda, scl} first stage
        logic [1:0]   s2;
        sebf_mst_st_t st;
        logic [5:0]   div;
        logic [1:0]   ph;
        logic [3:0]   bit_n;
        logic [7:0]   sr;
        logic         rd;
        logic         stp;
        logic         scl_low;
        logic         sda_low;
        logic [7:0]   rdata;
        logic         ack;
        logic         rv;
    } sebf_mst_t;

    sebf_mst_t q;
    sebf_mst_t d;
    logic      tick;

    assign tick          = (q.div == 6'(SCL_QTR_CYC - 1));
    assign cmd_ready     = (q.st == SEBM_IDLE) & (~cmd_start | (q.s2 == 2'h3));
    assign link.scl_m_o  = 1'b0;
    assign link.scl_m_oe = q.scl_low;
    assign link.sda_m_o  = 1'b0;
    assign link.sda_m_oe = q.sda_low;
    assign rsp_valid     = q.rv;
    assign rsp_data      = q.rdata;
    assign rsp_ack       = q.ack;

    // Quarter-bit phases: 0 set data, 1 clock up, 2 sample, 3 clock down
    always_comb
    begin
        d    = q;
        d.s1 = {link.sda, link.scl};
        d.s2 = q.s1;
        d.rv = 1'b0;
        d.div = tick ? 6'd0 : q.div + 6'd1;
        if (q.st == SEBM_IDLE)
        begin
            d.div = '0;
            d.ph  = '0;
            if (cmd_valid && cmd_ready)
            begin
                d.sr    = cmd_wdata;
                d.rd    = cmd_read;
                d.stp   = cmd_stop;
                d.bit_n = '0;
                d.st    = cmd_start ? SEBM_START : SEBM_BIT;
            end
        end
        else if (tick)
        begin
            d.ph = q.ph + 2'd1;
            unique case (q.st)
                SEBM_START:
                begin
                    // Entered from idle only; cmd_ready takes a start only while both lines read high
                    if (q.ph == 2'd0) d.sda_low = 1'b0;
                    if (q.ph == 2'd1) d.scl_low = 1'b0;
                    if (q.ph == 2'd2) d.sda_low = 1'b1;
                    if (q.ph == 2'd3)
                    begin
                        d.scl_low = 1'b1;
                        d.st      = SEBM_BIT;
                    end
                end
                SEBM_BIT:
                begin
                    if (q.ph == 2'd0)
                    begin
                        if (q.bit_n == BITS_BYTE)
                            d.sda_low = q.rd & ~q.stp;  // Nack the last read byte
                        else
                            d.sda_low = ~q.rd & ~q.sr[7];
                    end
                    if (q.ph == 2'd1) d.scl_low = 1'b0;
                    if (q.ph == 2'd2)
                    begin
                        if (q.bit_n == BITS_BYTE)
                            d.ack = ~q.s2[1];
                        else
                            d.sr = {q.sr[6:0], q.s2[1]};
                    end
                    if (q.ph == 2'd3)
                    begin
                        d.scl_low = 1'b1;
                        d.bit_n   = q.bit_n + 4'd1;
                        if (q.bit_n == BITS_BYTE)
                        begin
                            d.rv      = 1'b1;
                            d.rdata   = q.sr;
                            d.sda_low = 1'b0;
                            d.st      = q.stp ? SEBM_STOP : SEBM_IDLE;
                        end
                    end
                end
                SEBM_STOP:
                begin
                    if (q.ph == 2'd0) d.sda_low = 1'b1;
                    if (q.ph == 2'd1) d.scl_low = 1'b0;
                    if (q.ph == 2'd2) d.sda_low = 1'b0;
                    if (q.ph == 2'd3) d.st      = SEBM_IDLE;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q    <= '0;
            q.s1 <= 2'h3;
            q.s2 <= 2'h3;
            q.st <= SEBM_IDLE;
        end
        else
            q <= d;
    end
endmodule

// ### hw/sebf_slave.sv
// Purpose: Slave front of a serial EEPROM on a two-wire bus.
// Assumes: Bus lines arrive asynchronously; straps are static levels.
// Notes:   Received bytes go to a FIFO; a full FIFO withholds acknowledge.
// Contract
// - Data line only pulled low or released.
// - Data changes only while clock low.
// - Data edge during clock high is condition.
// - Respond only when chip selects match.
// - Eight devices share bus, four without pin.
// - Write-protect input high enables protection.
// - Variant without protect ignores that pin.
// - Low supply blocks all programming.
// - Ignore spikes up to 50 ns.
// - Programming cycle ends within 5 ms.
// - Transmit changes wait 300 ns after fall.
// - Master makes clock, start and stop.
// - Clock line is input only.
// - Master chooses direction; device follows.
// - Master starts only on idle bus.
// - Start is data fall, stop data rise.
// - Control byte: type, selects, direction bit.
// - No acknowledge while programming.
// - Acknowledge low through ninth clock high.
`timescale 1ns/100ps
module sebf_slave
    import sebf_pkg::*;
#(
    parameter int TWC_CYC_P = TWC_CYC,
    parameter bit HAS_WP    = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    sebf_link_if.dev         link,
    input  wire logic        chip_select_in_0,
    input  wire logic        chip_select_in_1,
    input  wire logic        chip_select_in_2,
    input  wire logic        write_protect_in,
    input  wire logic        supply_low_in,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    input  wire logic [7:0]  tx_data,
    output logic             tx_take,
    output logic             prog_start,
    output logic             prog_busy,
    output logic             prog_write_en,
    output logic             wp_active
);
    typedef enum logic [2:0] {
        SEBF_IDLE, SEBF_ADDR, SEBF_ACK, SEBF_RX, SEBF_TX, SEBF_TXACK, SEBF_SKIP
    } sebf_st_t;

    typedef struct packed {
        logic [1:0]      l1;      // {sda, scl} first stage
        logic [1:0]      l2;
        logic [1:0]      lf;      // Filtered lines
        logic [1:0][2:0] fcnt;
        logic [4:0]      p1;      // {low, wp, cs2, cs1, cs0}
        logic [4:0]      p2;
        sebf_st_t        st;
        logic [3:0]      cnt;
        logic [7:0]      sr;
        logic            rw;
        logic            wr;
        logic            drv;     // Pulling the data line low
        logic            pend;    // Level to apply after the hold delay
        logic [4:0]      hcnt;
        logic [17:0]     bsy;
        logic            pstart;
        logic            take;
    } sebf_slv_t;

    sebf_slv_t  q;
    sebf_slv_t  d;
    logic [1:0] nf;
    logic       scl_r;
    logic       scl_f;
    logic       start_c;
    logic       stop_c;
    logic       busy;
    logic       byte_end;
    logic       push;
    logic       push_ok;
    logic       cs_ok;
    logic       wp_lvl;

    sebf_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) sebf_fifo_inst (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (push_ok),
        .in_data   (q.sr),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Outputs straight from state
    assign link.sda_s_o  = 1'b0;
    assign link.sda_s_oe = q.drv;
    assign busy          = (q.bsy != '0);
    assign prog_busy     = busy;
    assign prog_start    = q.pstart;
    assign tx_take       = q.take;
    assign wp_lvl        = HAS_WP ? q.p2[3] : 1'b0;
    assign wp_active     = wp_lvl;
    // Array writes only while programming, unprotected and on good supply
    assign prog_write_en = busy & ~wp_lvl & ~q.p2[4];
    assign byte_end      = scl_f & (q.cnt == BITS_BYTE);
    assign cs_ok         = (q.sr[CTL_CS_MSB:CTL_CS_LSB] == q.p2[2:0])
                         & (q.sr[CTL_TYPE_MSB:CTL_TYPE_LSB] == TYPE_CODE);
    assign push          = byte_end & (q.st == SEBF_RX) & ~busy;

    // Glitch filter: a line must hold a new level FILT_CYC samples.
    // Edges are taken from the filtered copies only, never the raw pins.
    always_comb
    begin
        nf = q.lf;
        for (int i = 0; i < 2; i++)
        begin
            if (q.l2[i] != q.lf[i] && q.fcnt[i] == 3'(FILT_CYC - 1))
                nf[i] = q.l2[i];
        end
        scl_r   = nf[0] & ~q.lf[0];
        scl_f   = ~nf[0] & q.lf[0];
        start_c = ~nf[1] & q.lf[1] & nf[0] & q.lf[0];
        stop_c  = nf[1] & ~q.lf[1] & nf[0] & q.lf[0];
    end

    // Main receive/transmit sequencer
    always_comb
    begin
        d        = q;
        d.l1     = {link.sda, link.scl};
        d.l2     = q.l1;
        d.p1     = {supply_low_in, write_protect_in, chip_select_in_2,
                    chip_select_in_1, chip_select_in_0};
        d.p2     = q.p1;
        d.lf     = nf;
        d.pstart = 1'b0;
        d.take   = 1'b0;
        for (int i = 0; i < 2; i++)
            d.fcnt[i] = (q.l2[i] != q.lf[i] && nf[i] == q.lf[i]) ? q.fcnt[i] + 3'd1 : 3'd0;
        if (busy)
            d.bsy = q.bsy - 18'd1;
        // Deferred data change after the clock fell
        if (q.hcnt != '0)
        begin
            d.hcnt = q.hcnt - 5'd1;
            if (q.hcnt == 5'd1)
                d.drv = q.pend;
        end
        if (stop_c)
        begin
            // Stop ends any transfer; a completed write starts programming unless supply is low
            d.st   = SEBF_IDLE;
            d.drv  = 1'b0;
            d.hcnt = '0;
            d.wr   = 1'b0;
            if (q.wr && !q.p2[4])
            begin
                d.bsy    = 18'(TWC_CYC_P);
                d.pstart = 1'b1;
            end
        end
        else if (start_c)
        begin
            d.st   = SEBF_ADDR;
            d.cnt  = '0;
            d.drv  = 1'b0;
            d.hcnt = '0;
        end
        else if (scl_r)
        begin
            unique case (q.st)
                SEBF_ADDR, SEBF_RX:
                begin
                    d.sr  = {q.sr[6:0], nf[1]};
                    d.cnt = q.cnt + 4'd1;
                end
                SEBF_TX:    d.cnt = q.cnt + 4'd1;
                SEBF_TXACK: d.rw  = ~nf[1];   // Master ack keeps the read going
                default:    ;
            endcase
        end
        else if (scl_f)
        begin
            d.hcnt = 5'(HOLD_CYC);
            d.pend = 1'b0;
            unique case (q.st)
                SEBF_ADDR:
                begin
                    if (q.cnt == BITS_BYTE)
                    begin
                        d.rw = q.sr[CTL_RW_BIT];
                        d.st = (cs_ok && !busy) ? SEBF_ACK : SEBF_SKIP;
                        d.pend = cs_ok & ~busy;
                    end
                end
                SEBF_RX:
                begin
                    if (q.cnt == BITS_BYTE)
                    begin
                        d.pend = ~busy & push_ok;
                        d.st   = (~busy & push_ok) ? SEBF_ACK : SEBF_SKIP;
                        d.wr   = q.wr | (~busy & push_ok);
                    end
                end
                SEBF_ACK, SEBF_TXACK:
                begin
                    // After the ninth clock the master's chosen direction holds
                    d.cnt = '0;
                    if (q.rw)
                    begin
                        d.st   = SEBF_TX;
                        d.sr   = tx_data;
                        d.take = 1'b1;
                        d.pend = ~tx_data[7];
                    end
                    else
                        d.st = (q.st == SEBF_ACK) ? SEBF_RX : SEBF_SKIP;
                end
                SEBF_TX:
                begin
                    if (q.cnt == BITS_BYTE)
                        d.st = SEBF_TXACK;       // Release for the master's ack
                    else
                    begin
                        d.sr   = {q.sr[6:0], 1'b0};
                        d.pend = ~q.sr[6];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q      <= '0;
            q.l1   <= 2'h3;
            q.l2   <= 2'h3;
            q.lf   <= 2'h3;
            q.st   <= SEBF_IDLE;
        end
        else
            q <= d;
    end
endmodule

// ### shared/sebf_link_if.sv
// Purpose: Two-wire link between the master end and the slave front.
// Assumes: Both lines are open drain with pull-ups.
// Notes:   Line levels are resolved here from the enables.
`timescale 1ns/100ps
interface sebf_link_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Pull-up wins unless some party pulls low
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport mst (input scl, input sda, output scl_m_o, output scl_m_oe,
                 output sda_m_o, output sda_m_oe);
endinterface

// ### shared/sebf_pkg.sv
// Purpose: Shared constants for the two-wire EEPROM bus slave front and its master.
// Assumes: sys_clk at 50 MHz.
// Notes:   Times are kept in their own units; cycle counts derive from them, except SCL_QTR_CYC, which is set in cycles.
package sebf_pkg;
    localparam int CLK_KHZ       = 50_000;
    // Spike suppression: a pulse up to this width is ignored
    localparam int SPIKE_NS      = 50;
    localparam int FILT_CYC      = (SPIKE_NS * CLK_KHZ + 999_999) / 1_000_000 + 1;
    // Least delay from clock fall to a data change when transmitting
    localparam int HOLD_NS       = 300;
    localparam int HOLD_CYC      = (HOLD_NS * CLK_KHZ + 999_999) / 1_000_000;
    // Longest self-timed programming cycle
    localparam int TWC_MS        = 5;
    localparam int TWC_CYC       = TWC_MS * CLK_KHZ;
    // Master clock: one quarter of a bit period
    localparam int SCL_QTR_CYC   = 32;
    // Control byte layout
    localparam int CTL_TYPE_MSB  = 7;
    localparam int CTL_TYPE_LSB  = 4;
    localparam int CTL_CS_MSB    = 3;
    localparam int CTL_CS_LSB    = 1;
    localparam int CTL_RW_BIT    = 0;
    localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary value
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam int FIFO_W        = 8;
    localparam int FIFO_D        = 16;
endpackage

// ### verif/sebf_link_sva.sv
// Purpose: Wire checks on the two-wire link between master end and slave front.
// Assumes: Instantiated beside the link interface; one clock domain.
// Notes:   Sees the link only, so slave-internal state is judged by the bench.
`timescale 1ns/100ps
module sebf_link_sva
    import sebf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_m_o,
    input wire logic scl_m_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] gap_q;
    logic       scl_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Cycles since the raw clock line fell; saturates so idle time reads long
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            gap_q <= 8'hff;
        end
        else
        begin
            scl_q <= scl;
            if (scl_q && !scl)
                gap_q <= 8'h00;
            else if (gap_q != 8'hff)
                gap_q <= gap_q + 8'h01;
        end
    end

    a_open_drain_only: assert property (sda_s_o == 1'b0 && sda_m_o == 1'b0)
        else $error("data line driven high");
    a_scl_master_only: assert property (scl_m_o == 1'b0 && scl == !scl_m_oe)
        else $error("clock line not set by master alone");
    a_slave_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave moved data while clock high");
    a_slave_hold_gap: assert property ($changed(sda_s_oe) |-> int'(gap_q) >= HOLD_CYC)
        else $error("slave moved data too soon after clock fall");
    a_ack_thru_high: assert property ($rose(scl) && sda_s_oe |-> (sda_s_oe && !sda) [*8])
        else $error("slave low level not held in clock high");
    a_reset_idle: assert property ($rose(rst_n) |-> !sda_s_oe && !sda_m_oe && !scl_m_oe)
        else $error("lines not released after reset");
    a_start_idle_bus: assert property ($rose(sda_m_oe) && scl |-> $past(sda, 4) && $past(scl, 4))
        else $error("start on a busy bus");
    a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_stop_on_high: assert property ($fell(sda_m_oe) && scl |-> $past(scl, 8))
        else $error("master released data in a fresh clock high");

    // Main traffic shapes: slave drives, start, stop
    c_slave_drive: cover property ($rose(sda_s_oe));
    c_start: cover property ($rose(sda_m_oe) && scl);
    c_stop: cover property ($fell(sda_m_oe) && scl);
endmodule

// ### verif/serial_eeprom_bus_slave_front_tb.sv
// Purpose: Self-checking bench joining master end and slave front on one link.
// Assumes: Data bytes after the control byte of a write land in the receive FIFO; the control byte does not.
// Notes:   Programming cycle shortened to TWC cycles to keep the run short.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module serial_eeprom_bus_slave_front_tb;
    import sebf_pkg::*;
    localparam int TWC = 3000;
    logic sys_clk, rst_n, cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read;
    logic rsp_valid, rsp_ack, rx_valid, rx_ready, wp, sup_low;
    logic prog_busy, prog_write_en, wp_active;
    logic [7:0] cmd_wdata, rsp_data, rx_data, tx_data, b;
    logic [2:0] strap;
    logic [9:0] rspq[$];
    logic [7:0] rxq[$];
    int         n_mismatch, n_tests, seed;

    sebf_link_if lnk();
    sebf_master sebf_master_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk.mst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
        .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    sebf_slave #(.TWC_CYC_P(TWC)) sebf_slave_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(lnk.dev), .chip_select_in_0(strap[0]), .chip_select_in_1(strap[1]),
        .chip_select_in_2(strap[2]), .write_protect_in(wp), .supply_low_in(sup_low),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_take(), .prog_start(), .prog_busy(prog_busy),
        .prog_write_en(prog_write_en), .wp_active(wp_active));
    sebf_link_sva sebf_link_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .scl_m_o(lnk.scl_m_o), .scl_m_oe(lnk.scl_m_oe), .sda_m_o(lnk.sda_m_o),
        .sda_m_oe(lnk.sda_m_oe), .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe),
        .scl(lnk.scl), .sda(lnk.sda));

    task automatic final_report();
        $display("TB: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One command held until taken; its expected answer is queued first
    task automatic xfer(input logic st, input logic sp, input logic rd,
                        input logic [7:0] wd, input logic [9:0] e);
        int i;
        rspq.push_back(e);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_start <= st;
        cmd_stop  <= sp;
        cmd_read  <= rd;
        cmd_wdata <= wd;
        for (i = 0; i < 3000; i++)
        begin
            @(negedge sys_clk);
            if (cmd_ready === 1'b1)
                break;
        end
        // A command never taken is a hang, not a pass
        if (i == 3000)
        begin
            n_mismatch++;
            final_report();
        end
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++)
            @(negedge sys_clk);
        if (i == 3000)
        begin
            n_mismatch++;
            final_report();
        end
    endtask

    // Write control byte then n bytes, stop on the last; bytes past n_ack refused
    task automatic wr(input int n, input int n_ack);
        xfer(1'b1, 1'b0, 1'b0, {TYPE_CODE, strap, 1'b0}, 10'h100);
        for (int k = 0; k < n; k++)
        begin
            b = 8'($random(seed));
            if (k < n_ack)
                rxq.push_back(b);
            xfer(1'b0, k == n - 1, 1'b0, b, {1'b0, k < n_ack, 8'h00});
        end
    endtask

    // Programming length and write enable while it runs
    task automatic busy_chk(input logic pwe);
        int c;
        c = 0;
        for (int i = 0; i < 3000 && prog_busy !== 1'b1; i++)
            @(negedge sys_clk);
        while (prog_busy === 1'b1 && c < 10000)
        begin
            `CHK(prog_write_en, pwe)
            c++;
            @(negedge sys_clk);
        end
        `CHK(c, TWC)
    endtask

    // Free-running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Each master answer against the oldest note; a missing note reads unknown
    always @(negedge sys_clk)
        if (rsp_valid === 1'b1)
        begin
            logic [9:0] e;
            e = (rspq.size() != 0) ? rspq.pop_front() : 10'bx;
            `CHK(rsp_ack, e[8])
            if (e[9] === 1'b1)
                `CHK(rsp_data, e[7:0])
        end

    // Each byte leaving the receive FIFO against what was sent
    always @(negedge sys_clk)
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
        begin
            logic [7:0] x;
            // Pop once: the macro reads its expected value twice on a mismatch
            x = (rxq.size() != 0) ? rxq.pop_front() : 8'bx;
            `CHK(rx_data, x)
        end

    // Main sequence
    initial
    begin
        seed = 96;
        {cmd_valid, cmd_start, cmd_stop, cmd_read, wp, sup_low} = 6'h00;
        {n_mismatch, n_tests} = 0;
        cmd_wdata = 8'h00;
        rx_ready = 1'b1;
        rst_n = 1'b0;
        strap = 3'($random(seed));
        tx_data = 8'($random(seed));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // All eight selects, then a foreign type code
        for (int k = 0; k < 9; k++)
            xfer(1'b1, 1'b1, 1'b0, {k < 8 ? TYPE_CODE : ~TYPE_CODE, k < 8 ? 3'(k) : strap,
                 1'b0}, {1'b0, 3'(k) == strap && k < 8, 8'h00});
        $display("TB: address match done");
        b = tx_data;
        xfer(1'b1, 1'b0, 1'b0, {TYPE_CODE, strap, 1'b1}, 10'h100);
        xfer(1'b0, 1'b0, 1'b1, 8'h00, {2'b11, b});
        xfer(1'b0, 1'b1, 1'b1, 8'h00, {2'b10, b});
        $display("TB: read done");
        // Plain, protected and low-supply writes
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            wp      <= (k == 1);
            sup_low <= (k == 2);
            wr(2, 2);
            if (k == 2)
                repeat (600)
                begin
                    @(negedge sys_clk);
                    `CHK(prog_busy, 1'b0)
                end
            else if (k == 0)
                fork
                    busy_chk(1'b1);
                    xfer(1'b1, 1'b1, 1'b0, {TYPE_CODE, strap, 1'b0}, 10'h000);
                join
            else
                busy_chk(1'b0);
            `CHK(wp_active, wp)
        end
        $display("TB: write cases done");
        @(posedge sys_clk);
        wp      <= 1'b0;
        sup_low <= 1'b0;
        rx_ready <= 1'b0;
        wr(FIFO_D + 1, FIFO_D);
        busy_chk(1'b1);
        @(posedge sys_clk);
        rx_ready <= 1'b1;
        for (int i = 0; i < 100 && rx_valid !== 1'b0; i++)
            @(negedge sys_clk);
        `CHK(rx_valid, 1'b0)
        `CHK(rxq.size(), 0)
        $display("TB: fifo fill done");
        final_report();
    end
endmodule
